/* File: hdl/btx_pkg.sv */
// Constants and carriers for the toggle and flag-branch executor
package btx_pkg;
    localparam int          PC_W           = 21;
    localparam int          ADDR_W         = 12;
    localparam logic [3:0]  OPC_TOGGLE     = 4'h7;
    localparam logic [7:0]  OPC_BR_OVF     = 8'hE4;
    localparam logic [7:0]  OPC_BR_ZERO    = 8'hE0;
    localparam logic [7:0]  IDX_LIMIT      = 8'h5F;
    localparam logic [7:0]  COMMON_SPLIT   = 8'h80;
    localparam logic [3:0]  COMMON_LO_BANK = 4'h0;
    localparam logic [3:0]  COMMON_HI_BANK = 4'hF;
    localparam logic [1:0]  Q1 = 2'h0;
    localparam logic [1:0]  Q2 = 2'h1;
    localparam logic [1:0]  Q3 = 2'h2;
    localparam logic [1:0]  Q4 = 2'h3;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } mem_wr_t;

    typedef struct packed {
        logic            we;
        logic [PC_W-1:0] target;
    } pc_wr_t;
endpackage

/* File: hdl/btx_qphase.sv */
// Four-phase sequencer producing the Q1..Q4 phase and a cycle-end pulse in Q4
`timescale 1ns/1ps
`default_nettype none
module btx_qphase (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    output logic      [1:0] o_phase,
    output logic            o_last
);
    logic [1:0] phase_ff;
    wire  [1:0] nxt_phase = phase_ff + 2'h1;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            phase_ff <= btx_pkg::Q1;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign o_phase = phase_ff;
    assign o_last  = (phase_ff == btx_pkg::Q4);
endmodule
`default_nettype wire

/* File: hdl/btx_exec.sv */
// Executor for bit toggle and overflow/zero relative branches
`timescale 1ns/1ps
`default_nettype none
module btx_exec (
    input  wire logic                    I_CLK,
    input  wire logic                    I_SYS_RST,
    input  wire logic             [15:0] I_INSTR,
    input  wire logic                    I_INSTR_VALID,
    input  wire logic [btx_pkg::PC_W-1:0] I_PC,
    input  wire logic              [3:0] I_BANK_SEL,
    input  wire logic              [7:0] I_FSR2,
    input  wire logic                    I_EXT_EN,
    input  wire logic              [7:0] I_RDATA,
    input  wire logic                    I_FLAG_OVF,
    input  wire logic                    I_FLAG_ZERO,
    output logic      [1:0]              O_PHASE,
    output logic [btx_pkg::ADDR_W-1:0]   O_RADDR,
    output logic                         O_RE,
    output btx_pkg::mem_wr_t             O_MEM_WR,
    output btx_pkg::pc_wr_t              O_PC_WR,
    output logic                         O_FLAG_WE,
    output logic                         O_FLUSH
);
    typedef enum logic [2:0] {
        S_EXEC  = 3'b001,
        S_NOP   = 3'b010,
        S_IDLE  = 3'b100
    } state_t;

    state_t                      state_ff;
    state_t                      nxt_state;
    logic [1:0]                  phase;
    logic                        q_last;
    logic [15:0]                 ir_ff;
    logic                        ir_ok_ff;
    logic [7:0]                  data_ff;
    logic [btx_pkg::PC_W-1:0]    target_ff;
    logic                        take_ff;
    logic [1:0]                  phase_ff;
    logic [btx_pkg::ADDR_W-1:0]  raddr_ff;
    logic                        re_ff;
    btx_pkg::mem_wr_t            mem_wr_ff;
    btx_pkg::pc_wr_t             pc_wr_ff;
    logic                        flush_ff;
    logic                        flag_we_ff;

    btx_qphase u_qphase (
        .i_clk   (I_CLK),
        .i_rst   (I_SYS_RST),
        .o_phase (phase),
        .o_last  (q_last)
    );

    // Resolve an 8-bit file field to a full data address
    function automatic logic [btx_pkg::ADDR_W-1:0] resolve(
        input logic [7:0] f, input logic a, input logic ext,
        input logic [3:0] bank_sel, input logic [7:0] fsr);
        logic [btx_pkg::ADDR_W-1:0] r;
        r = {bank_sel, f};
        if (!a && ext && (f <= btx_pkg::IDX_LIMIT)) begin
            r = {4'h0, fsr} + {4'h0, f};
        end else if (!a) begin
            r = (f < btx_pkg::COMMON_SPLIT) ?
                {btx_pkg::COMMON_LO_BANK, f} :
                {btx_pkg::COMMON_HI_BANK, f};
        end
        return r;
    endfunction

    wire        is_tgl  = ir_ok_ff && (ir_ff[15:12] == btx_pkg::OPC_TOGGLE);
    wire        is_br_ovf  = ir_ok_ff &&
                             (ir_ff[15:8] == btx_pkg::OPC_BR_OVF);
    wire        is_br_zero = ir_ok_ff &&
                             (ir_ff[15:8] == btx_pkg::OPC_BR_ZERO);
    wire [2:0]  bit_idx = ir_ff[11:9];
    wire        acc_bit = ir_ff[8];
    wire [7:0]  fld     = ir_ff[7:0];
    wire [7:0]  tgl_mask = 8'h01 << bit_idx;
    wire        cond    = (is_br_ovf && I_FLAG_OVF) ||
                          (is_br_zero && I_FLAG_ZERO);
    // Offset sign-extended and doubled; I_PC already points past the word
    wire [btx_pkg::PC_W-1:0] off2 =
        {{(btx_pkg::PC_W-9){fld[7]}}, fld, 1'b0};
    wire [btx_pkg::PC_W-1:0] nxt_target = I_PC + off2;
    wire [btx_pkg::ADDR_W-1:0] faddr =
        resolve(fld, acc_bit, I_EXT_EN, I_BANK_SEL, I_FSR2);
    wire        in_exec = (state_ff == S_EXEC);

    // Latch the word in Q4 so it decodes in the next Q1; a taken branch
    // drops the prefetched word, hence the no-op cycle
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            ir_ff    <= 16'h0000;
            ir_ok_ff <= 1'b0;
        end else if (q_last) begin
            ir_ff    <= I_INSTR;
            ir_ok_ff <= I_INSTR_VALID && (nxt_state == S_EXEC);
        end
    end

    always_comb begin
        nxt_state = state_ff;
        if (q_last) begin
            case (state_ff)
                S_EXEC: begin
                    nxt_state = take_ff ? S_NOP : S_EXEC;
                end
                default: begin
                    nxt_state = S_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state_ff  <= S_IDLE;
            data_ff   <= 8'h00;
            target_ff <= '0;
            take_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (in_exec && phase == btx_pkg::Q2) begin
                data_ff   <= I_RDATA;
                target_ff <= nxt_target;
            end
            if (in_exec && phase == btx_pkg::Q3) begin
                data_ff <= data_ff ^ tgl_mask;
                take_ff <= cond;
            end else if (q_last) begin
                take_ff <= 1'b0;
            end
        end
    end

    // Registered outputs are set one clock ahead, so O_PHASE and each
    // one-cycle strobe stand in the same phase
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            phase_ff  <= btx_pkg::Q1;
            raddr_ff  <= '0;
            re_ff     <= 1'b0;
            mem_wr_ff <= '0;
            pc_wr_ff  <= '0;
            flush_ff  <= 1'b0;
            flag_we_ff <= 1'b0;
        end else begin
            phase_ff  <= phase + 2'h1;
            flag_we_ff <= 1'b0;
            re_ff     <= in_exec && is_tgl && phase == btx_pkg::Q1;
            raddr_ff  <= faddr;
            mem_wr_ff.we    <= in_exec && is_tgl &&
                               phase == btx_pkg::Q3;
            mem_wr_ff.addr  <= faddr;
            mem_wr_ff.wdata <= data_ff ^ tgl_mask;
            pc_wr_ff.we     <= in_exec && cond &&
                               phase == btx_pkg::Q3;
            pc_wr_ff.target <= target_ff;
            flush_ff        <= in_exec && cond && phase == btx_pkg::Q3;
        end
    end

    assign O_PHASE   = phase_ff;
    assign O_RADDR   = raddr_ff;
    assign O_RE      = re_ff;
    assign O_MEM_WR  = mem_wr_ff;
    assign O_PC_WR   = pc_wr_ff;
    assign O_FLUSH   = flush_ff;
    assign O_FLAG_WE = flag_we_ff;

    a_pc_write_taken: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_PC_WR.we |-> O_PHASE == btx_pkg::Q4 && $past(cond))
        else $error("PC written outside Q4 or without condition");
    a_toggle_one_bit: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_MEM_WR.we |->
        (O_MEM_WR.wdata ^ $past(I_RDATA, 2)) == (8'h01 << bit_idx))
        else $error("Toggle changed other than the selected bit");
    a_toggle_q4_write: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_MEM_WR.we |-> O_PHASE == btx_pkg::Q4 && $past(O_RE, 2))
        else $error("Toggle write not in Q4 after Q2 read");
    a_read_q2: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_RE |-> O_PHASE == btx_pkg::Q2 && in_exec)
        else $error("File read outside Q2 of an exec cycle");
    a_write_back_addr: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_MEM_WR.we |-> O_MEM_WR.addr == $past(O_RADDR, 2))
        else $error("Toggle wrote a location other than the one read");
    a_taken_nop: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_PC_WR.we |=> state_ff == S_NOP ##4 state_ff == S_EXEC)
        else $error("Taken branch lacks one no-op cycle");
    a_flush_pair: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_FLUSH == O_PC_WR.we)
        else $error("Flush not paired with PC write");
    a_nop_quiet: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        state_ff == S_NOP |-> !O_RE && !O_MEM_WR.we && !O_PC_WR.we)
        else $error("Activity during the no-op cycle");
    a_ovf_cond: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        in_exec && is_br_ovf && phase == btx_pkg::Q3 && !I_FLAG_OVF
        |=> !O_PC_WR.we)
        else $error("Overflow branch taken with flag clear");
    a_ovf_taken: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        in_exec && is_br_ovf && phase == btx_pkg::Q3 && I_FLAG_OVF
        |=> O_PC_WR.we)
        else $error("Overflow branch not taken with flag set");
    a_zero_cond: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        in_exec && is_br_zero && phase == btx_pkg::Q3 && I_FLAG_ZERO
        |=> O_PC_WR.we)
        else $error("Zero branch not taken with flag set");
    a_zero_clear: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        in_exec && is_br_zero && phase == btx_pkg::Q3 && !I_FLAG_ZERO
        |=> !O_PC_WR.we)
        else $error("Zero branch taken with flag clear");
    a_target_calc: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_PC_WR.we |-> O_PC_WR.target == $past(I_PC, 2) +
        {{(btx_pkg::PC_W-9){fld[7]}}, fld, 1'b0})
        else $error("Branch target mismatch");
    a_flags_kept: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        !O_FLAG_WE)
        else $error("Status flag write asserted");
    a_access_bank: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_RE && acc_bit |-> O_RADDR == {$past(I_BANK_SEL), $past(fld)})
        else $error("Banked address not from bank select");
    a_common_bank: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_RE && !acc_bit &&
        (!$past(I_EXT_EN) || fld > btx_pkg::IDX_LIMIT) |->
        O_RADDR[btx_pkg::ADDR_W-1 -: 4] == (fld[7] ?
        btx_pkg::COMMON_HI_BANK : btx_pkg::COMMON_LO_BANK))
        else $error("Common bank address wrong");
    a_indexed_mode: assert property (
        @(posedge I_CLK) disable iff (I_SYS_RST)
        O_RE && !acc_bit && $past(I_EXT_EN) && fld <= btx_pkg::IDX_LIMIT |->
        O_RADDR == {4'h0, $past(I_FSR2)} + {4'h0, fld})
        else $error("Indexed literal offset address wrong");
endmodule
`default_nettype wire

/* File: testbench/btx_mem_model.sv */
// Data memory partner for the toggle executor
`timescale 1ns/1ps
`default_nettype none
module btx_mem_model (
    input  wire logic                       i_clk,
    input  wire logic                       i_re,
    input  wire logic [btx_pkg::ADDR_W-1:0] i_raddr,
    input  wire btx_pkg::mem_wr_t           i_wr,
    output logic      [7:0]                 o_rdata
);
    logic [7:0] store [0:4095];
    // Bus idles inverted so a stale read never passes for real data
    assign o_rdata = i_re ? store[i_raddr] : ~store[i_raddr];
    initial begin
        for (int i = 0; i < 4096; i++)
            store[i] = i[7:0];
    end
    always @(posedge i_clk) begin
        if (i_wr.we)
            store[i_wr.addr] <= i_wr.wdata;
    end
endmodule
`default_nettype wire

/* File: testbench/bit_toggle_and_flag_branch_exec_bench.sv */
// Self-checking bench for the toggle and flag-branch executor
`timescale 1ns/1ps
`default_nettype none
module bit_toggle_and_flag_branch_exec_bench;
    typedef struct {
        logic        tog, br;
        logic [11:0] a;
        logic [7:0]  m;
        logic [20:0] t;
    } exp_t;
    logic        clk = 1'b0, rst = 1'b1, ivalid = 1'b0, skip = 1'b0;
    logic        ext = 1'b0, ovf = 1'b0, zf = 1'b0, last;
    logic [15:0] instr = 16'h0000;
    logic [20:0] pc = 21'h000000;
    logic [3:0]  bank_sel = 4'h0;
    logic [1:0]  qcnt = 2'h0;
    logic [7:0]  fsr = 8'h00, rdata, wd;
    logic [31:0] lfsr = 32'h0E8F2E6C;
    logic [1:0]  phase;
    logic [11:0] raddr;
    logic        re, fwe, flush;
    btx_pkg::mem_wr_t mwr;
    btx_pkg::pc_wr_t  pwr;
    exp_t        q[$], cur;
    int          errors = 0, n_tests = 0;

    btx_exec uut (.I_CLK(clk), .I_SYS_RST(rst), .I_INSTR(instr),
        .I_INSTR_VALID(ivalid), .I_PC(pc), .I_BANK_SEL(bank_sel),
        .I_FSR2(fsr), .I_EXT_EN(ext), .I_RDATA(rdata), .I_FLAG_OVF(ovf),
        .I_FLAG_ZERO(zf), .O_PHASE(phase), .O_RADDR(raddr), .O_RE(re),
        .O_MEM_WR(mwr), .O_PC_WR(pwr), .O_FLAG_WE(fwe), .O_FLUSH(flush));
    btx_mem_model mem (.i_clk(clk), .i_re(re), .i_raddr(raddr),
        .i_wr(mwr), .o_rdata(rdata));

    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk_flag(input logic got, input logic want);
        n_tests++;
        if (got !== want) begin
            errors++;
            $display("unexpected strobe at %0t: %b", $time, got);
        end
    endtask
    task automatic chk_val(input logic [20:0] got, input logic [20:0] want);
        n_tests++;
        if (got !== want) begin
            errors++;
            $display("unexpected value at %0t: %h", $time, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Model the word taken now; side inputs hold for its exec cycle
    task automatic sample_edge();
        exp_t        e;
        logic [31:0] r;
        logic [7:0]  f;
        logic [20:0] p;
        lfsr = step(lfsr);
        r = lfsr;
        f = instr[7:0];
        p = {r[31:12], 1'b0};
        e = '{default: 0};
        if (ivalid && !skip && instr[15:12] == btx_pkg::OPC_TOGGLE) begin
            e.tog = 1'b1;
            e.m = 8'h01 << instr[11:9];
            if (instr[8])
                e.a = {r[3:0], f};
            else if (r[4] && f <= btx_pkg::IDX_LIMIT)
                e.a = {5'h00, r[14:8]} + {4'h0, f};
            else if (f[7])
                e.a = {btx_pkg::COMMON_HI_BANK, f};
            else
                e.a = {btx_pkg::COMMON_LO_BANK, f};
        end
        e.br = ivalid && !skip && (r[5] && instr[15:8] == btx_pkg::OPC_BR_OVF
            || r[6] && instr[15:8] == btx_pkg::OPC_BR_ZERO);
        e.t = p + {{12{f[7]}}, f, 1'b0};
        skip = e.br;
        q.push_back(e);
        bank_sel <= r[3:0];
        ext <= r[4];
        ovf <= r[5];
        zf <= r[6];
        fsr <= {1'b0, r[14:8]};
        pc <= p;
        lfsr = step(lfsr);
        r = lfsr;
        // Boundary offsets and addresses turn up often on purpose
        f = r[1] ? (r[0] ? 8'h80 : 8'h7F) : (r[0] ? 8'h5F : 8'h60);
        if (r[3:2] != 2'h0)
            f = r[15:8];
        ivalid <= r[31:28] != 4'h0;
        case (r[5:4])
            2'h0: instr <= {btx_pkg::OPC_TOGGLE, r[11:8], f};
            2'h1: instr <= {btx_pkg::OPC_BR_OVF, f};
            2'h2: instr <= {btx_pkg::OPC_BR_ZERO, f};
            default: instr <= {4'h2, r[11:8], f};
        endcase
    endtask

    always #20 clk = ~clk;
    // One process, so the queue is filled before it is looked at
    always @(posedge clk) begin
        if (!rst) begin
            chk_val({19'h00000, phase}, {19'h00000, qcnt});
            qcnt = qcnt + 2'h1;
        end
        if (!rst && phase === btx_pkg::Q4)
            sample_edge();
        if (!rst && q.size() > 0) begin
            cur = q[0];
            last = phase === btx_pkg::Q4 && q.size() == 2;
            chk_flag(fwe, 1'b0);
            chk_flag(flush, pwr.we);
            chk_flag(re, phase === btx_pkg::Q2 && cur.tog);
            chk_flag(mwr.we, last && cur.tog);
            chk_flag(pwr.we, last && cur.br);
            if (phase === btx_pkg::Q2 && cur.tog)
                chk_val({9'h000, raddr}, {9'h000, cur.a});
            if (last && cur.tog) begin
                wd = mem.store[cur.a] ^ cur.m;
                chk_val({9'h000, mwr.addr}, {9'h000, cur.a});
                chk_val({13'h0000, mwr.wdata}, {13'h0000, wd});
            end
            if (last && cur.br)
                chk_val(pwr.target, cur.t);
            if (last)
                void'(q.pop_front());
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (1600) @(posedge clk);
        end_of_test();
    end
    initial begin
        #100000;
        errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
